// [include/ffcr_pkg.sv]
package ffcr_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    // serial opcodes, sent msb first
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_FLAG = 8'h70;
    localparam logic [7:0] OP_RD_CFG = 8'hB5;
    localparam logic [7:0] OP_WR_CFG = 8'hB1;
    localparam logic [7:0] OP_ADDR4_EN = 8'hB7;
    localparam logic [7:0] OP_ADDR4_EX = 8'hE9;
    // flag status bit positions
    localparam int unsigned FS_READY = 7;
    localparam int unsigned FS_ERASE_SUSP = 6;
    localparam int unsigned FS_ERASE_ERR = 5;
    localparam int unsigned FS_WRITE_ERR = 4;
    localparam int unsigned FS_WRITE_SUSP = 2;
    localparam int unsigned FS_PROT_ERR = 1;
    localparam int unsigned FS_ADDR4 = 0;
    // persistent config layout and blank value
    localparam int unsigned CFG_DUMMY_LSB = 12;
    localparam int unsigned CFG_ADDR3 = 0;
    localparam logic [15:0] CFG_RESET = 16'hFFFF;
    localparam logic [3:0] DUMMY_CODE_LO = 4'h0;
    localparam logic [3:0] DUMMY_CODE_HI = 4'hF;
    localparam logic [3:0] DUMMY_FAST_DEF = 4'h8;
    localparam logic [3:0] DUMMY_QUAD_DEF = 4'hA;
    // frame bit counts
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] CFG_FRAME_BITS = 5'h18;
    localparam logic [4:0] CFG_BITS = 5'h10;
    // self-timed config write
    localparam int unsigned CFG_WRITE_TIME_NS = 2000;
    localparam int unsigned CFG_WRITE_CYCLES = (CFG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host serial clock half period
    localparam int unsigned SCLK_HALF_CYCLES = 8;
    // host apb register offsets
    localparam logic [7:0] HR_CMD = 8'h00;
    localparam logic [7:0] HR_WDATA = 8'h04;
    localparam logic [7:0] HR_RDATA = 8'h08;
    localparam logic [7:0] HR_STATUS = 8'h0C;
    // host command and status register fields
    localparam int unsigned HC_WLEN_LSB = 8;
    localparam int unsigned HC_RLEN_LSB = 10;
    localparam int unsigned HS_BUSY = 0;
    localparam int unsigned HS_DONE = 1;

    typedef enum logic [2:0] {
        DEV_CMD = 3'b000,
        DEV_RD_FLAG = 3'b001,
        DEV_RD_CFG = 3'b010,
        DEV_WR_CFG = 3'b011,
        DEV_IGNORE = 3'b100
    } ffcr_dev_state_t;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_RUN = 2'b01,
        HST_GAP = 2'b10
    } ffcr_host_state_t;
endpackage : ffcr_pkg

// [include/ffcr_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ffcr_link_if;
    logic sclk;
    logic cs_n;
    logic io0;
    logic io1_out;
    logic io1_oe_n;
    logic io1;
    // line floats high when nobody drives it
    assign io1 = io1_oe_n ? 1'b1 : io1_out;
    modport dev (
        input sclk,
        input cs_n,
        input io0,
        output io1_out,
        output io1_oe_n
    );
    modport host (
        output sclk,
        output cs_n,
        output io0,
        input io1
    );
endinterface : ffcr_link_if
`default_nettype wire

// [core/ffcr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ffcr_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // async in, synced out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_reg <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : ffcr_sync
`default_nettype wire

// [core/ffcr_device.sv]
`timescale 1ns/1ps
`default_nettype none
module ffcr_device #(
    parameter int unsigned CFG_WRITE_CYCLES = ffcr_pkg::CFG_WRITE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // serial link
    ffcr_link_if.dev lnk,
    // internal array operations
    input wire logic op_busy_i,
    input wire logic erase_fail_i,
    input wire logic write_fail_i,
    input wire logic prot_fail_i,
    input wire logic zero_to_one_i,
    input wire logic program_supply_high_i,
    input wire logic erase_susp_i,
    input wire logic write_susp_i,
    // settings for the read path, then the wip and wel status bits
    output logic [3:0] dummy_fast_o,
    output logic [3:0] dummy_quad_o,
    output logic four_byte_o,
    output logic wip_o,
    output logic wel_o
);
    import ffcr_pkg::*;

    localparam int unsigned TW = $clog2(CFG_WRITE_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LOAD = TW'(CFG_WRITE_CYCLES - 1);

    ffcr_dev_state_t state_reg;
    ffcr_dev_state_t state_next;
    logic [2:0] pins_s;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic [7:0] cmd_reg;
    logic [4:0] bit_cnt_reg;
    logic [15:0] data_reg;
    logic [4:0] out_cnt_reg;
    logic io1_reg;
    logic io1_oe_n_reg;
    logic [15:0] cfg_reg;
    logic [15:0] pend_reg;
    logic wcfg_busy_reg;
    logic [TW-1:0] timer_reg;
    logic wel_reg;
    logic four_byte_reg;
    logic erase_err_reg;
    logic write_err_reg;
    logic prot_err_reg;
    logic op_busy_prev_reg;
    logic wip_reg;
    logic [3:0] dummy_fast_reg;
    logic [3:0] dummy_quad_reg;

    // pins cross into clk_i before anything looks at them
    ffcr_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h2)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({lnk.sclk, lnk.cs_n, lnk.io0}),
        .q_o(pins_s)
    );

    wire sclk_s = pins_s[2];
    wire cs_s = pins_s[1];
    wire io0_s = pins_s[0];
    wire rise = sclk_s & ~sclk_prev_reg & ~cs_s;
    wire fall = ~sclk_s & sclk_prev_reg & ~cs_s;
    wire cs_rise = cs_s & ~cs_prev_reg;
    wire [7:0] cmd_full = {cmd_reg[6:0], io0_s};
    wire last_cmd_bit = (state_reg == DEV_CMD) & rise & (bit_cnt_reg == CMD_BITS - 5'h01);
    wire short_done = cs_rise & (state_reg == DEV_IGNORE) & (bit_cnt_reg == CMD_BITS);
    wire cfg_commit = cs_rise & (state_reg == DEV_WR_CFG) & (bit_cnt_reg == CFG_FRAME_BITS);
    wire cfg_done = wcfg_busy_reg & (timer_reg == '0);
    wire op_start = op_busy_i & ~op_busy_prev_reg;
    wire write_bad = write_fail_i | (zero_to_one_i & program_supply_high_i);
    wire [3:0] dummy_code = cfg_reg[CFG_DUMMY_LSB +: 4];
    wire dummy_dflt = (dummy_code == DUMMY_CODE_LO) | (dummy_code == DUMMY_CODE_HI);
    wire rd_state = (state_next == DEV_RD_FLAG) | (state_next == DEV_RD_CFG);

    // flags are assembled from live state only, software cannot write them
    logic [7:0] flag_byte;
    always_comb begin
        flag_byte = 8'h00;
        flag_byte[FS_READY] = ~wip_reg;
        flag_byte[FS_ERASE_SUSP] = erase_susp_i;
        flag_byte[FS_ERASE_ERR] = erase_err_reg;
        flag_byte[FS_WRITE_ERR] = write_err_reg;
        flag_byte[FS_WRITE_SUSP] = write_susp_i;
        flag_byte[FS_PROT_ERR] = prot_err_reg;
        flag_byte[FS_ADDR4] = four_byte_reg;
    end

    always_comb begin
        state_next = state_reg;
        if (cs_s) begin
            state_next = DEV_CMD;
        end else if (last_cmd_bit) begin
            case (cmd_full)
                OP_RD_FLAG: state_next = DEV_RD_FLAG;
                OP_RD_CFG: state_next = DEV_RD_CFG;
                OP_WR_CFG: state_next = (wel_reg & ~wip_reg) ? DEV_WR_CFG : DEV_IGNORE;
                default: state_next = DEV_IGNORE;
            endcase
        end
    end

    // frame side: shifting in on rising edges, out on falling edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= DEV_CMD;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            cmd_reg <= 8'h00;
            bit_cnt_reg <= 5'h00;
            data_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            sclk_prev_reg <= sclk_s;
            cs_prev_reg <= cs_s;
            if (cs_s) begin
                bit_cnt_reg <= 5'h00;
            end else if (rise) begin
                if (bit_cnt_reg != 5'h1F) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
                if (bit_cnt_reg < CMD_BITS) begin
                    cmd_reg <= cmd_full;
                end
                data_reg <= {data_reg[14:0], io0_s};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_cnt_reg <= 5'h00;
            io1_reg <= 1'b0;
            io1_oe_n_reg <= 1'b1;
        end else begin
            io1_oe_n_reg <= ~rd_state;
            if (cs_s | ~rd_state) begin
                out_cnt_reg <= 5'h00;
                io1_reg <= 1'b0;
            end else if (fall & (state_reg == DEV_RD_FLAG)) begin
                io1_reg <= flag_byte[3'h7 - out_cnt_reg[2:0]];
                out_cnt_reg <= {2'b00, out_cnt_reg[2:0] + 3'h1};
            end else if (fall & (state_reg == DEV_RD_CFG)) begin
                if (out_cnt_reg < CFG_BITS) begin
                    io1_reg <= cfg_reg[4'hF - out_cnt_reg[3:0]];
                    out_cnt_reg <= out_cnt_reg + 5'h01;
                end else begin
                    io1_reg <= 1'b0;
                end
            end
        end
    end

    // self-timed config write and the write enable latch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_reg <= CFG_RESET;
            pend_reg <= CFG_RESET;
            wcfg_busy_reg <= 1'b0;
            timer_reg <= '0;
            wel_reg <= 1'b0;
            four_byte_reg <= ~CFG_RESET[CFG_ADDR3];
        end else begin
            if (cfg_commit) begin
                pend_reg <= data_reg;
                wcfg_busy_reg <= 1'b1;
                timer_reg <= TIMER_LOAD;
            end else if (cfg_done) begin
                cfg_reg <= pend_reg;
                four_byte_reg <= ~pend_reg[CFG_ADDR3];
                wcfg_busy_reg <= 1'b0;
                wel_reg <= 1'b0;
            end else if (wcfg_busy_reg) begin
                timer_reg <= timer_reg - TW'(1);
            end
            if (short_done & ~wip_reg) begin
                case (cmd_reg)
                    OP_WR_EN: wel_reg <= 1'b1;
                    OP_WR_DIS: wel_reg <= 1'b0;
                    OP_ADDR4_EN: four_byte_reg <= wel_reg ? 1'b1 : four_byte_reg;
                    OP_ADDR4_EX: four_byte_reg <= wel_reg ? 1'b0 : four_byte_reg;
                    default: wel_reg <= wel_reg;
                endcase
            end
        end
    end

    // error flags: a new event beats the clear at the next operation start
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            erase_err_reg <= 1'b0;
            write_err_reg <= 1'b0;
            prot_err_reg <= 1'b0;
            op_busy_prev_reg <= 1'b0;
            wip_reg <= 1'b0;
        end else begin
            op_busy_prev_reg <= op_busy_i;
            erase_err_reg <= erase_fail_i | (erase_err_reg & ~op_start);
            write_err_reg <= write_bad | (write_err_reg & ~op_start);
            prot_err_reg <= prot_fail_i | (prot_err_reg & ~op_start);
            wip_reg <= wcfg_busy_reg | op_busy_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dummy_fast_reg <= DUMMY_FAST_DEF;
            dummy_quad_reg <= DUMMY_QUAD_DEF;
        end else begin
            dummy_fast_reg <= dummy_dflt ? DUMMY_FAST_DEF : dummy_code;
            dummy_quad_reg <= dummy_dflt ? DUMMY_QUAD_DEF : dummy_code;
        end
    end

    assign lnk.io1_out = io1_reg;
    assign lnk.io1_oe_n = io1_oe_n_reg;
    assign dummy_fast_o = dummy_fast_reg;
    assign dummy_quad_o = dummy_quad_reg;
    assign four_byte_o = four_byte_reg;
    assign wip_o = wip_reg;
    assign wel_o = wel_reg;
endmodule : ffcr_device
`default_nettype wire

// [core/ffcr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ffcr_host #(
    parameter int unsigned HALF_CYCLES = ffcr_pkg::SCLK_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial link
    ffcr_link_if.host lnk
);
    import ffcr_pkg::*;

    localparam logic [7:0] DIV_LAST = 8'(HALF_CYCLES - 1);

    ffcr_host_state_t state_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic [15:0] wdata_reg;
    logic [31:0] rx_reg;
    logic [23:0] tx_reg;
    logic [6:0] bits_left_reg;
    logic [7:0] div_reg;
    logic sclk_reg;
    logic cs_n_reg;
    logic io0_reg;
    logic done_reg;
    logic io1_s;

    ffcr_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(lnk.io1),
        .q_o(io1_s)
    );

    wire access = psel_i & penable_i;
    wire complete = access & pready_reg;
    wire busy = (state_reg != HST_IDLE);
    // a command written while busy is dropped rather than queued
    wire start = complete & pwrite_i & (paddr_i == HR_CMD) & ~busy;
    wire wr_wdata = complete & pwrite_i & (paddr_i == HR_WDATA);
    wire [3:0] nbytes = 4'(pwdata_i[HC_WLEN_LSB +: 2]) + 4'(pwdata_i[HC_RLEN_LSB +: 3]) + 4'h1;
    wire [6:0] nbits = {nbytes, 3'b000};
    wire tick = (div_reg == DIV_LAST);
    wire [31:0] status = {30'h0, done_reg, busy};
    wire [31:0] rd_mux = (paddr_i == HR_WDATA) ? {16'h0000, wdata_reg} :
                         (paddr_i == HR_RDATA) ? rx_reg :
                         (paddr_i == HR_STATUS) ? status : 32'h0000_0000;

    // one wait state so read data comes from a flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            wdata_reg <= 16'h0000;
        end else begin
            pready_reg <= access & ~pready_reg;
            if (access & ~pready_reg) begin
                prdata_reg <= rd_mux;
            end
            if (wr_wdata) begin
                wdata_reg <= pwdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= HST_IDLE;
            tx_reg <= 24'h00_0000;
            rx_reg <= 32'h0000_0000;
            bits_left_reg <= 7'h00;
            div_reg <= 8'h00;
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            io0_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            case (state_reg)
                HST_IDLE: begin
                    if (start) begin
                        state_reg <= HST_RUN;
                        cs_n_reg <= 1'b0;
                        sclk_reg <= 1'b0;
                        div_reg <= 8'h00;
                        io0_reg <= pwdata_i[7];
                        tx_reg <= {pwdata_i[6:0], wdata_reg, 1'b0};
                        bits_left_reg <= nbits;
                        done_reg <= 1'b0;
                    end
                end
                HST_RUN: begin
                    if (tick & ~sclk_reg) begin
                        sclk_reg <= 1'b1;
                        rx_reg <= {rx_reg[30:0], io1_s};
                        bits_left_reg <= bits_left_reg - 7'h01;
                    end else if (tick) begin
                        sclk_reg <= 1'b0;
                        if (bits_left_reg == 7'h00) begin
                            state_reg <= HST_GAP;
                            cs_n_reg <= 1'b1;
                        end else begin
                            io0_reg <= tx_reg[23];
                            tx_reg <= {tx_reg[22:0], 1'b0};
                        end
                    end
                end
                HST_GAP: begin
                    if (tick) begin
                        state_reg <= HST_IDLE;
                        done_reg <= 1'b1;
                    end
                end
                default: state_reg <= HST_IDLE;
            endcase
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = 1'b0;
    assign lnk.sclk = sclk_reg;
    assign lnk.cs_n = cs_n_reg;
    assign lnk.io0 = io0_reg;
endmodule : ffcr_host
`default_nettype wire

// [dv/ffcr_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ffcr_link_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // link lines
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic io0,
    input wire logic io1_out,
    input wire logic io1_oe_n,
    input wire logic io1
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic sclk_q;
    logic [5:0] bit_cnt_reg;
    logic [5:0] bit_cnt_next;
    wire sclk_rise = sclk && !sclk_q;
    assign bit_cnt_next = cs_n ? 6'h00 : (sclk_rise ? bit_cnt_reg + 6'h01 : bit_cnt_reg);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_q <= 1'b0;
            bit_cnt_reg <= 6'h00;
        end else begin
            sclk_q <= sclk;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    sequence s_low8;
        !sclk [*8] ##1 sclk;
    endsequence
    sequence s_high8;
        sclk [*8] ##1 !sclk;
    endsequence

    property p_start; $fell(cs_n) |-> s_low8; endproperty
    property p_low; $fell(sclk) && !cs_n |-> s_low8; endproperty
    property p_high; $rose(sclk) |-> s_high8; endproperty
    property p_idle; cs_n |-> !sclk; endproperty
    property p_io0; !cs_n && sclk |-> $stable(io0); endproperty
    // frames end on whole bytes only
    property p_bits; $rose(cs_n) |-> (bit_cnt_reg != 6'h00) && (bit_cnt_reg[2:0] == 3'h0); endproperty
    property p_release; $rose(cs_n) |-> ##[0:5] io1_oe_n; endproperty
    property p_drive; $fell(io1_oe_n) |-> !cs_n; endproperty
    // a released line must also have its output flop parked low
    property p_pullup; io1_oe_n |-> io1 && !io1_out; endproperty
    property p_reset; disable iff (1'b0) reset_i |=> cs_n && io1_oe_n && !sclk; endproperty

    a_start: assert property (p_start) else $error("sclk not low 8 cycles after select");
    a_low: assert property (p_low) else $error("sclk low phase wrong");
    a_high: assert property (p_high) else $error("sclk high phase wrong");
    a_idle: assert property (p_idle) else $error("sclk runs outside frame");
    a_io0: assert property (p_io0) else $error("io0 moved while sclk high");
    a_bits: assert property (p_bits) else $error("frame not whole bytes");
    a_release: assert property (p_release) else $error("io1 still driven after deselect");
    a_drive: assert property (p_drive) else $error("io1 driven while deselected");
    a_pullup: assert property (p_pullup) else $error("released io1 not idle");
    a_reset: assert property (p_reset) else $error("link not idle in reset");
endmodule : ffcr_link_sva
`default_nettype wire

// [dv/ffcr_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ffcr_tb_top;
    import ffcr_pkg::*;
    logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic op_busy_i, erase_fail_i, write_fail_i, prot_fail_i, zero_to_one_i;
    logic program_supply_high_i, erase_susp_i, write_susp_i;
    logic [3:0] dummy_fast_o, dummy_quad_o;
    logic four_byte_o, wip_o, wel_o;
    int n_errors, n_tests;

    ffcr_link_if lnk();
    ffcr_host #(.HALF_CYCLES(8)) ffcr_host_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .lnk(lnk));
    // short write time keeps the run brief
    ffcr_device #(.CFG_WRITE_CYCLES(3)) ffcr_device_i (.clk_i(clk_i), .reset_i(reset_i), .lnk(lnk),
        .op_busy_i(op_busy_i), .erase_fail_i(erase_fail_i), .write_fail_i(write_fail_i),
        .prot_fail_i(prot_fail_i), .zero_to_one_i(zero_to_one_i),
        .program_supply_high_i(program_supply_high_i), .erase_susp_i(erase_susp_i),
        .write_susp_i(write_susp_i), .dummy_fast_o(dummy_fast_o), .dummy_quad_o(dummy_quad_o),
        .four_byte_o(four_byte_o), .wip_o(wip_o), .wel_o(wel_o));
    ffcr_link_sva ffcr_link_sva_i (.clk_i(clk_i), .reset_i(reset_i), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
        .io0(lnk.io0), .io1_out(lnk.io1_out), .io1_oe_n(lnk.io1_oe_n), .io1(lnk.io1));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task end_sim;
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_data

    task chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task frame(input logic [7:0] op, input logic [1:0] wl, input logic [2:0] rl, input logic [15:0] wd);
        logic [31:0] st;
        apb(1'b1, HR_WDATA, {16'h0000, wd}, st);
        apb(1'b1, HR_CMD, {19'h00000, rl, wl, op}, st);
        st = 32'h00000000;
        while (st[HS_DONE] !== 1'b1 || st[HS_BUSY] !== 1'b0)
            apb(1'b0, HR_STATUS, 32'h00000000, st);
        apb(1'b0, HR_RDATA, 32'h00000000, rd);
    endtask : frame

    task wait_wip;
        for (int i = 0; i < 50 && wip_o !== 1'b0; i++)
            @(posedge clk_i);
    endtask : wait_wip

    task t_reset;
        chk_bit(lnk.io1, 1'b1);
        apb(1'b0, 8'h40, 32'h00000000, rd);
        chk_data(rd, 32'h00000000);
        chk_bit(pslverr_o, 1'b0);
        frame(OP_RD_FLAG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], 8'h80);
        chk_data({28'h0, dummy_fast_o}, {28'h0, DUMMY_FAST_DEF});
        chk_data({28'h0, dummy_quad_o}, {28'h0, DUMMY_QUAD_DEF});
        frame(OP_RD_CFG, 2'h0, 3'h3, 16'h0000);
        chk_data(rd[23:0], 24'hFFFF00);
        // a one-byte read cuts the output short
        frame(OP_RD_CFG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], 8'hFF);
        frame(OP_RD_CFG, 2'h0, 3'h2, 16'h0000);
        chk_data(rd[15:0], CFG_RESET);
    endtask : t_reset

    task t_flags;
        op_busy_i <= 1'b1;
        erase_susp_i <= 1'b1;
        write_susp_i <= 1'b1;
        @(posedge clk_i);
        erase_fail_i <= 1'b1;
        write_fail_i <= 1'b1;
        prot_fail_i <= 1'b1;
        @(posedge clk_i);
        {erase_fail_i, write_fail_i, prot_fail_i} <= 3'b000;
        frame(OP_RD_FLAG, 2'h0, 3'h2, 16'h0000);
        chk_data(rd[15:0], 16'h7676);
        chk_bit(wip_o, 1'b1);
        op_busy_i <= 1'b0;
        erase_susp_i <= 1'b0;
        write_susp_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        frame(OP_RD_FLAG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], 8'hB2);
        chk_bit(wip_o, 1'b0);
        op_busy_i <= 1'b1;
        program_supply_high_i <= 1'b1;
        @(posedge clk_i);
        zero_to_one_i <= 1'b1;
        @(posedge clk_i);
        zero_to_one_i <= 1'b0;
        frame(OP_RD_FLAG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], 8'h10);
        op_busy_i <= 1'b0;
        program_supply_high_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        // a fresh operation start clears the sticky errors
        op_busy_i <= 1'b1;
        @(posedge clk_i);
        op_busy_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        frame(OP_RD_FLAG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], 8'h80);
    endtask : t_flags

    task t_refused;
        frame(OP_WR_CFG, 2'h2, 3'h0, 16'h5FFE);
        wait_wip();
        frame(OP_RD_CFG, 2'h0, 3'h2, 16'h0000);
        chk_data(rd[15:0], CFG_RESET);
        frame(OP_ADDR4_EN, 2'h0, 3'h0, 16'h0000);
        chk_bit(four_byte_o, 1'b0);
        frame(OP_WR_EN, 2'h0, 3'h0, 16'h0000);
        frame(OP_ADDR4_EN, 2'h0, 3'h0, 16'h0000);
        chk_bit(four_byte_o, 1'b1);
        frame(OP_ADDR4_EX, 2'h0, 3'h0, 16'h0000);
        chk_bit(four_byte_o, 1'b0);
        frame(OP_WR_DIS, 2'h0, 3'h0, 16'h0000);
        chk_bit(wel_o, 1'b0);
    endtask : t_refused

    task t_cfg_write(input logic [15:0] v);
        logic [3:0] code;
        logic [3:0] ef;
        logic [3:0] eq;
        code = v[15:12];
        ef = (code == 4'h0 || code == 4'hF) ? 4'h8 : code;
        eq = (code == 4'h0 || code == 4'hF) ? 4'hA : code;
        frame(OP_WR_EN, 2'h0, 3'h0, 16'h0000);
        chk_bit(wel_o, 1'b1);
        frame(OP_WR_CFG, 2'h2, 3'h0, v);
        wait_wip();
        chk_data({28'h0, dummy_fast_o}, {28'h0, ef});
        chk_data({28'h0, dummy_quad_o}, {28'h0, eq});
        chk_bit(four_byte_o, ~v[0]);
        chk_bit(wel_o, 1'b0);
        frame(OP_RD_CFG, 2'h0, 3'h2, 16'h0000);
        chk_data(rd[15:0], v);
        frame(OP_RD_FLAG, 2'h0, 3'h1, 16'h0000);
        chk_data(rd[7:0], {7'h40, ~v[0]});
    endtask : t_cfg_write

    initial begin
        reset_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'b000;
        paddr_i = 8'h00;
        pwdata_i = 32'h00000000;
        {op_busy_i, erase_fail_i, write_fail_i, prot_fail_i} = 4'h0;
        {zero_to_one_i, program_supply_high_i, erase_susp_i, write_susp_i} = 4'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_flags();
        t_refused();
        // fixed bits kept at one, boundary dummy codes and both address lengths
        t_cfg_write(16'h5FFE);
        t_cfg_write(16'h0FFF);
        t_cfg_write(16'hEFFE);
        t_cfg_write(16'h1FFF);
        t_cfg_write(16'hFFFF);
        end_sim();
    end

    initial begin
        repeat (80000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end
endmodule : ffcr_tb_top
`default_nettype wire
